// file: hw/eprom_host.sv
`timescale 1ns/1ps
module eprom_host #(
	parameter int unsigned PULSE_CYCLES = eprom_pkg::PROG_PULSE_CYCLES
) (
	// Clock and reset
	input  logic        clk,
	input  logic        reset,
	input  logic        ce,
	// Link to the device
	link_if.host        link,
	// Command port
	input  logic        cmd_valid,
	output logic        cmd_ready,
	input  logic        cmd_program,
	input  logic [15:0] cmd_addr,
	input  logic [7:0]  cmd_data,
	input  logic        cmd_last,
	// Read stream
	output logic        rd_valid,
	input  logic        rd_ready,
	output logic [7:0]  rd_data,
	output logic        rd_is_crc,
	output logic        rd_crc_bad,
	// Status
	output logic        done,
	output logic        error
);
	import eprom_pkg::*;

	typedef enum logic [11:0] {
		H_IDLE  = 12'h001, H_RESET = 12'h002, H_CMD  = 12'h004, H_ALO   = 12'h008,
		H_AHI   = 12'h010, H_DATA  = 12'h020, H_CRC  = 12'h040, H_PAGE  = 12'h080,
		H_PCRC  = 12'h100, H_PULSE = 12'h200, H_VFY  = 12'h400, H_NEXT  = 12'h800
	} hstate_e;

	hstate_e     state_q, state_d;
	logic [2:0]  bit_q, bit_d;
	logic [7:0]  sh_q, sh_d;
	logic [7:0]  crc_q, crc_d;
	logic [15:0] addr_q, addr_d;
	logic [7:0]  data_q, data_d;
	logic        prog_q, prog_d;
	logic        last_q, last_d;
	logic [1:0]  tries_q, tries_d;
	logic [13:0] pcnt_q, pcnt_d;
	logic        done_q, done_d;
	logic        error_q, error_d;
	logic        sending, receiving, stall, go, bit_end;
	logic        push, fifo_ready;
	logic [9:0]  push_data;
	logic [9:0]  pop_data;
	logic [7:0]  rx_byte;

	assign sending   = state_q inside {H_CMD, H_ALO, H_AHI, H_DATA};
	assign receiving = state_q inside {H_CRC, H_PAGE, H_PCRC, H_VFY};
	// Read data waits for buffer room rather than being lost
	assign stall     = (state_q inside {H_PAGE, H_PCRC}) && !fifo_ready;
	assign go        = ce && !stall && (sending || receiving || state_q == H_RESET ||
	                   (state_q == H_PULSE && pcnt_q == '0));
	assign bit_end   = (bit_q == LAST_BIT);
	// RULE_20: bits travel LSB first
	assign rx_byte   = {link.slot_rbit, sh_q[7:1]};

	assign link.slot_valid = go;
	assign link.slot_wbit  = sh_q[0];
	assign link.slot_kind  = (state_q == H_RESET) ? SLOT_RESET :
	                         sending ? SLOT_WRITE :
	                         (state_q == H_PULSE) ? SLOT_PULSE : SLOT_READ;
	assign cmd_ready = ce && (state_q inside {H_IDLE, H_NEXT});
	assign done      = done_q;
	assign error     = error_q;

	always_comb begin
		state_d = state_q;
		bit_d   = bit_q;
		sh_d    = sh_q;
		crc_d   = crc_q;
		addr_d  = addr_q;
		data_d  = data_q;
		prog_d  = prog_q;
		last_d  = last_q;
		tries_d = tries_q;
		pcnt_d  = pcnt_q;
		done_d  = 1'b0;
		error_d = 1'b0;
		push    = 1'b0;
		push_data = {2'b00, rx_byte};
		if (state_q == H_IDLE && cmd_valid && cmd_ready) begin
			addr_d  = cmd_addr;
			data_d  = cmd_data;
			prog_d  = cmd_program;
			last_d  = cmd_last;
			tries_d = 2'h0;
			state_d = H_RESET;
		end else if (state_q == H_NEXT && cmd_valid && cmd_ready) begin
			// RULE_17: next pass sends only a data byte
			data_d  = cmd_data;
			last_d  = cmd_last;
			sh_d    = cmd_data;
			state_d = H_DATA;
		end else if (state_q == H_RESET && go) begin
			// RULE_01: command byte selects read or program
			sh_d    = prog_q ? CMD_PROGRAM : CMD_READ_PAGE;
			crc_d   = CRC_SEED;
			bit_d   = BIT_RESET;
			state_d = H_CMD;
		end else if (sending && go) begin
			crc_d = crc8_step(crc_q, sh_q[0]);
			sh_d  = sh_q >> 1;
			bit_d = bit_q + 3'h1;
			if (bit_end) begin
				// RULE_02: low address byte, then high
				unique case (state_q)
					H_CMD: begin
						sh_d    = addr_q[7:0];
						state_d = H_ALO;
					end
					H_ALO: begin
						sh_d    = addr_q[15:8];
						state_d = H_AHI;
					end
					H_AHI: begin
						sh_d    = data_q;
						state_d = prog_q ? H_DATA : H_CRC;
					end
					H_DATA: state_d = H_CRC;
				endcase
			end
		end else if (receiving && go) begin
			sh_d  = rx_byte;
			bit_d = bit_q + 3'h1;
			if (state_q == H_PAGE) begin
				crc_d = crc8_step(crc_q, link.slot_rbit);
			end
			if (bit_end) begin
				unique case (state_q)
					H_CRC: begin
						if (rx_byte != crc_q) begin
							// RULE_04: bad CRC means reset and repeat
							state_d = (tries_q == MAX_TRIES) ? H_IDLE : H_RESET;
							tries_d = tries_q + 2'h1;
							done_d  = (tries_q == MAX_TRIES);
							error_d = (tries_q == MAX_TRIES);
						end else if (prog_q) begin
							// RULE_11: pulse only after CRC agrees
							pcnt_d  = 14'(PULSE_CYCLES - 1);
							state_d = H_PULSE;
						end else begin
							crc_d   = CRC_SEED;
							state_d = H_PAGE;
						end
					end
					H_PAGE: begin
						push = 1'b1;
						if (addr_q[4:0] == PAGE_LAST) begin
							state_d = H_PCRC;
						end else begin
							addr_d = addr_q + 16'h0001;
						end
					end
					H_PCRC: begin
						push      = 1'b1;
						push_data = {1'b1, rx_byte != crc_q, rx_byte};
						crc_d     = CRC_SEED;
						addr_d    = addr_q + 16'h0001;
						state_d   = H_PAGE;
						if (addr_q[6:0] == LAST_ADDR) begin
							state_d = H_IDLE;
							done_d  = 1'b1;
						end
					end
					H_VFY: begin
						if ((rx_byte & ~data_q) != 8'h00) begin
							// RULE_14: retry the same address
							state_d = (tries_q == MAX_TRIES) ? H_IDLE : H_RESET;
							tries_d = tries_q + 2'h1;
							done_d  = (tries_q == MAX_TRIES);
							error_d = (tries_q == MAX_TRIES);
						end else begin
							addr_d  = addr_q + 16'h0001;
							crc_d   = 8'(addr_q + 16'h0001);
							tries_d = 2'h0;
							state_d = last_q ? H_IDLE : H_NEXT;
							done_d  = last_q;
						end
					end
				endcase
			end
		end else if (state_q == H_PULSE) begin
			if (pcnt_q != '0) begin
				pcnt_d = ce ? pcnt_q - 14'h0001 : pcnt_q;
			end else if (go) begin
				// RULE_13: eight verify reads follow the pulse
				bit_d   = BIT_RESET;
				state_d = H_VFY;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= H_IDLE;
			bit_q   <= BIT_RESET;
			sh_q    <= ERASED_BYTE;
			crc_q   <= CRC_SEED;
			addr_q  <= 16'h0000;
			data_q  <= ERASED_BYTE;
			prog_q  <= 1'b0;
			last_q  <= 1'b1;
			tries_q <= 2'h0;
			pcnt_q  <= 14'h0000;
			done_q  <= 1'b0;
			error_q <= 1'b0;
		end else if (ce) begin
			state_q <= state_d;
			bit_q   <= bit_d;
			sh_q    <= sh_d;
			crc_q   <= crc_d;
			addr_q  <= addr_d;
			data_q  <= data_d;
			prog_q  <= prog_d;
			last_q  <= last_d;
			tries_q <= tries_d;
			pcnt_q  <= pcnt_d;
			done_q  <= done_d;
			error_q <= error_d;
		end
	end

	hold_fifo #(
		.W     (10),
		.DEPTH (2)
	) u_fifo (
		.clk       (clk),
		.reset     (reset),
		.ce        (ce),
		.in_valid  (push),
		.in_ready  (fifo_ready),
		.in_data   (push_data),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.out_data  (pop_data)
	);

	assign rd_data    = pop_data[7:0];
	assign rd_crc_bad = pop_data[8];
	assign rd_is_crc  = pop_data[9];
endmodule : eprom_host

// file: include/eprom_pkg.sv
package eprom_pkg;

	// Memory command bytes
	localparam logic [7:0] CMD_READ_PAGE = 8'hc3;
	localparam logic [7:0] CMD_PROGRAM   = 8'h0f;

	// Memory geometry
	localparam int         MEM_BYTES     = 128;
	localparam logic [6:0] LAST_ADDR     = 7'h7f;
	localparam logic [4:0] PAGE_LAST     = 5'h1f;
	localparam logic [7:0] ERASED_BYTE   = 8'hff;
	localparam logic [2:0] LAST_BIT      = 3'h7;

	// Values after reset
	localparam logic [7:0] CRC_SEED      = 8'h00;
	localparam logic [6:0] ADDR_RESET    = 7'h00;
	localparam logic [2:0] BIT_RESET     = 3'h0;

	// Slot kinds on the link
	localparam logic [1:0] SLOT_RESET    = 2'h0;
	localparam logic [1:0] SLOT_WRITE    = 2'h1;
	localparam logic [1:0] SLOT_READ     = 2'h2;
	localparam logic [1:0] SLOT_PULSE    = 2'h3;

	// Programming pulse, 480 us at 20 MHz
	localparam int         CLK_MHZ       = 20;
	localparam int         PROG_PULSE_US = 480;
	localparam int         PROG_PULSE_CYCLES = PROG_PULSE_US * CLK_MHZ;

	// Host gives up after one more than this many failed attempts
	localparam logic [1:0] MAX_TRIES     = 2'h3;

	// Reflected polynomial x^8+x^5+x^4+1
	localparam logic [7:0] CRC_POLY_LSB  = 8'h8c;

	// RULE_22: LSB-first CRC step
	function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic b);
		logic fb;
		fb = crc[0] ^ b;
		return fb ? ((crc >> 1) ^ CRC_POLY_LSB) : (crc >> 1);
	endfunction : crc8_step

endpackage : eprom_pkg

// file: include/link_if.sv
`timescale 1ns/1ps
interface link_if;
	logic       slot_valid;
	logic [1:0] slot_kind;
	logic       slot_wbit;
	logic       slot_rbit;

	modport host (
		output slot_valid,
		output slot_kind,
		output slot_wbit,
		input  slot_rbit
	);

	modport device (
		input  slot_valid,
		input  slot_kind,
		input  slot_wbit,
		output slot_rbit
	);
endinterface : link_if

// file: hw/hold_fifo.sv
`timescale 1ns/1ps
module hold_fifo #(
	parameter int W     = 10,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  logic         clk,
	input  logic         reset,
	input  logic         ce,
	// Fill side
	input  logic         in_valid,
	output logic         in_ready,
	input  logic [W-1:0] in_data,
	// Drain side
	output logic         out_valid,
	input  logic         out_ready,
	output logic [W-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [W-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [PW:0]   cnt_q;
	logic          push;
	logic          pop;

	// Count is one bit wider than the pointers, so full compares at that width
	assign in_ready  = ce && (cnt_q != (PW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push      = in_valid && in_ready;
	assign pop       = ce && out_valid && out_ready;
	assign out_data  = mem_q[rd_q];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// Full stalls the filler, so a slow drain never drops a word
	always_ff @(posedge clk) begin
		if (reset) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (ce) begin
			if (push) begin
				wr_q <= wr_q + PW'(1);
			end
			if (pop) begin
				rd_q <= rd_q + PW'(1);
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + (PW+1)'(1);
			end else if (pop && !push) begin
				cnt_q <= cnt_q - (PW+1)'(1);
			end
		end
	end
endmodule : hold_fifo

// file: hw/eprom_dev.sv
// Operation
// RULE_01: C3h starts paged read at address
// RULE_02: address sent low byte then high
// RULE_03: CRC of command and address returned first
// RULE_04: host resets and repeats on bad CRC
// RULE_05: data to page end, then page CRC
// RULE_06: each next page: 32 bytes plus CRC
// RULE_07: ones after last page CRC until reset
// RULE_08: bus reset aborts any command
// RULE_09: 0Fh program: address, data, then CRC
// RULE_10: program address masked to seven bits
// RULE_11: host pulses only after good CRC
// RULE_12: pulse clears bits where data is zero
// RULE_13: eight verify reads return stored byte
// RULE_14: host retries address when verify fails
// RULE_15: address always increments after verify reads
// RULE_16: new low address seeds the CRC
// RULE_17: next pass: data byte, then CRC
// RULE_18: first pass CRC covers command through data
// RULE_19: device programs on any pulse, no check
// RULE_20: all bytes least significant bit first
// RULE_21: write-protected page refuses programming
// RULE_22: CRC polynomial x^8+x^5+x^4+1, LSB first
`timescale 1ns/1ps
module eprom_dev (
	// Clock and reset
	input  logic       clk,
	input  logic       reset,
	input  logic       ce,
	// Link to the host
	link_if.device     link,
	// Page write protection
	input  logic [3:0] wp_page,
	// Status
	output logic       prog_refused
);
	import eprom_pkg::*;

	typedef enum logic [9:0] {
		D_CMD     = 10'h001, D_ALO   = 10'h002, D_AHI     = 10'h004, D_DATA_RX = 10'h008,
		D_CRC_TX  = 10'h010, D_PAGE  = 10'h020, D_PCRC_TX = 10'h040, D_WAIT    = 10'h080,
		D_VFY_TX  = 10'h100, D_ONES  = 10'h200
	} dstate_e;

	dstate_e    state_q, state_d;
	logic [2:0] bit_q;
	logic [7:0] rx_q;
	logic [7:0] tx_q, tx_d;
	logic [7:0] crc_q, crc_d;
	logic [6:0] addr_q, addr_d;
	logic [7:0] data_q;
	logic       rd_mode_q, rd_mode_d;
	logic       refused_q;
	// Erased cells read as ones; the array has no reset, it is nonvolatile
	logic [7:0] mem [MEM_BYTES] = '{default: ERASED_BYTE};

	logic       rst_slot, wr_slot, rd_slot, pulse_slot;
	logic       rx_state, tx_state, bit_end, mask_bit, in_bit, protect, do_prog;
	logic [7:0] rx_byte, crc_wr, crc_rd, programmed;
	logic [6:0] next_addr;

	assign rst_slot   = ce && link.slot_valid && (link.slot_kind == SLOT_RESET);
	assign wr_slot    = ce && link.slot_valid && (link.slot_kind == SLOT_WRITE);
	assign rd_slot    = ce && link.slot_valid && (link.slot_kind == SLOT_READ);
	assign pulse_slot = ce && link.slot_valid && (link.slot_kind == SLOT_PULSE);
	assign rx_state   = state_q inside {D_CMD, D_ALO, D_AHI, D_DATA_RX};
	assign tx_state   = state_q inside {D_CRC_TX, D_PAGE, D_PCRC_TX, D_VFY_TX};
	assign bit_end    = (bit_q == LAST_BIT);
	// RULE_20: received bits fill from the top
	assign rx_byte    = {link.slot_wbit, rx_q[7:1]};
	// RULE_10: upper nine address bits forced to zero
	assign mask_bit   = !rd_mode_q && ((state_q == D_ALO && bit_end) || state_q == D_AHI);
	assign in_bit     = link.slot_wbit && !mask_bit;
	// RULE_22: same generator for received and sent bits
	assign crc_wr     = crc8_step(crc_q, in_bit);
	assign crc_rd     = crc8_step(crc_q, tx_q[0]);
	assign next_addr  = addr_q + 7'h01;
	// RULE_12: programming only ever clears bits
	assign programmed = mem[addr_q] & data_q;
	// RULE_21: protection follows the page of the selected byte
	assign protect    = wp_page[addr_q[6:5]];
	// RULE_19: no CRC check gates the pulse
	assign do_prog    = pulse_slot && (state_q == D_WAIT);

	// RULE_20: sent bits leave from the bottom
	assign link.slot_rbit = tx_q[0];
	assign prog_refused   = refused_q;

	always_comb begin
		state_d   = state_q;
		tx_d      = tx_q;
		crc_d     = crc_q;
		addr_d    = addr_q;
		rd_mode_d = rd_mode_q;
		if (rst_slot) begin
			// RULE_08: reset returns to command wait
			state_d = D_CMD;
			tx_d    = ERASED_BYTE;
			crc_d   = CRC_SEED;
		end else if (wr_slot && rx_state) begin
			// RULE_18: command, address and data shift into the CRC
			crc_d = crc_wr;
			if (bit_end) begin
				unique case (state_q)
					D_CMD: begin
						// RULE_01: paged read command
						// RULE_09: program command
						rd_mode_d = (rx_byte == CMD_READ_PAGE);
						state_d   = (rx_byte == CMD_READ_PAGE || rx_byte == CMD_PROGRAM) ?
						            D_ALO : D_ONES;
					end
					D_ALO: begin
						// RULE_02: low address byte first
						addr_d  = rx_byte[6:0];
						state_d = D_AHI;
					end
					D_AHI: begin
						// RULE_03: command and address CRC goes out first
						tx_d    = crc_wr;
						state_d = rd_mode_q ? D_CRC_TX : D_DATA_RX;
					end
					D_DATA_RX: begin
						// RULE_17: CRC over seed and new data byte
						tx_d    = crc_wr;
						state_d = D_CRC_TX;
					end
				endcase
			end
		end else if (rd_slot && tx_state) begin
			tx_d = {1'b1, tx_q[7:1]};
			if (state_q == D_PAGE) begin
				crc_d = crc_rd;
			end
			if (bit_end) begin
				unique case (state_q)
					D_CRC_TX: begin
						crc_d   = CRC_SEED;
						tx_d    = rd_mode_q ? mem[addr_q] : ERASED_BYTE;
						state_d = rd_mode_q ? D_PAGE : D_WAIT;
					end
					D_PAGE: begin
						// RULE_05: page CRC after the page's last byte
						if (addr_q[4:0] == PAGE_LAST) begin
							tx_d    = crc_rd;
							state_d = D_PCRC_TX;
						end else begin
							addr_d = next_addr;
							tx_d   = mem[next_addr];
						end
					end
					D_PCRC_TX: begin
						if (addr_q == LAST_ADDR) begin
							// RULE_07: ones until the next bus reset
							tx_d    = ERASED_BYTE;
							state_d = D_ONES;
						end else begin
							// RULE_06: next page starts with a fresh CRC
							addr_d  = next_addr;
							tx_d    = mem[next_addr];
							crc_d   = CRC_SEED;
							state_d = D_PAGE;
						end
					end
					D_VFY_TX: begin
						// RULE_15: increment whatever the verify showed
						// RULE_16: low byte of new address seeds the CRC
						addr_d  = next_addr;
						crc_d   = {1'b0, next_addr};
						tx_d    = ERASED_BYTE;
						state_d = D_DATA_RX;
					end
				endcase
			end
		end else if (do_prog) begin
			// RULE_13: verify returns AND of all data written, or the stored byte unchanged on a protected page
			tx_d    = protect ? mem[addr_q] : programmed;
			state_d = D_VFY_TX;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q   <= D_CMD;
			tx_q      <= ERASED_BYTE;
			crc_q     <= CRC_SEED;
			addr_q    <= ADDR_RESET;
			rd_mode_q <= 1'b0;
		end else if (ce) begin
			state_q   <= state_d;
			tx_q      <= tx_d;
			crc_q     <= crc_d;
			addr_q    <= addr_d;
			rd_mode_q <= rd_mode_d;
		end
	end

	// Bit position counts only slots that move a bit
	always_ff @(posedge clk) begin
		if (reset) begin
			bit_q <= BIT_RESET;
		end else if (rst_slot || do_prog) begin
			bit_q <= BIT_RESET;
		end else if ((wr_slot && rx_state) || (rd_slot && tx_state)) begin
			bit_q <= bit_q + 3'h1;
		end
	end

	// Scratchpad takes the data byte as it arrives
	always_ff @(posedge clk) begin
		if (reset) begin
			rx_q   <= ERASED_BYTE;
			data_q <= ERASED_BYTE;
		end else if (wr_slot && rx_state) begin
			rx_q <= rx_byte;
			if (bit_end && state_q == D_DATA_RX) begin
				data_q <= rx_byte;
			end
		end
	end

	// RULE_12: selected byte takes the AND on the pulse
	// RULE_21: protected page keeps its contents
	always_ff @(posedge clk) begin
		if (do_prog && !protect) begin
			mem[addr_q] <= programmed;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			refused_q <= 1'b0;
		end else if (ce) begin
			refused_q <= do_prog && protect;
		end
	end
endmodule : eprom_dev

// file: tb/link_sva.sv
`timescale 1ns/1ps
module link_sva (
	// Clock and reset
	input logic       clk,
	input logic       reset,
	// Link signals
	input logic       slot_valid,
	input logic [1:0] slot_kind,
	input logic       slot_wbit,
	input logic       slot_rbit
);
	import eprom_pkg::*;
	logic       wr;
	logic       rd;
	logic       rs;
	logic       pu;
	logic       is_prog;
	logic [5:0] wcnt_q;
	logic [3:0] rcnt_q;
	logic [7:0] cmd_q;
	logic [7:0] crc_q;
	assign wr = slot_valid && (slot_kind == SLOT_WRITE);
	assign rd = slot_valid && (slot_kind == SLOT_READ);
	assign rs = slot_valid && (slot_kind == SLOT_RESET);
	assign pu = slot_valid && (slot_kind == SLOT_PULSE);
	assign is_prog = (cmd_q == CMD_PROGRAM);
	// Counters restart on every bus reset, then saturate
	always_ff @(posedge clk) begin
		if (reset || rs) wcnt_q <= 6'h00;
		else if (wr && wcnt_q != 6'h20) wcnt_q <= wcnt_q + 6'h01;
	end
	always_ff @(posedge clk) begin
		if (reset || rs) rcnt_q <= 4'h0;
		else if (rd && rcnt_q != 4'h8) rcnt_q <= rcnt_q + 4'h1;
	end
	always_ff @(posedge clk) begin
		if (reset || rs) cmd_q <= 8'h00;
		else if (wr && wcnt_q < 6'h08) cmd_q <= {slot_wbit, cmd_q[7:1]};
	end
	// First pass only; later passes reseed inside the device
	always_ff @(posedge clk) begin
		if (reset || rs) crc_q <= CRC_SEED;
		else if (wr && (wcnt_q < 6'h18 || (wcnt_q < 6'h20 && is_prog)))
			crc_q <= (crc_q >> 1) ^ ((crc_q[0] ^ slot_wbit) ? CRC_POLY_LSB : 8'h00);
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_reset_slot; rs; endsequence
	sequence s_pulse_slot; pu; endsequence
	sequence s_no_write; !wr; endsequence
	sequence s_last_hdr_bit; wr && wcnt_q == (is_prog ? 6'h1f : 6'h17); endsequence
	a_reset_rbit_idle: assert property (s_reset_slot |=> slot_rbit)
		else $error("read line not idle after bus reset");
	a_addr_before_read: assert property (rd |-> wcnt_q >= 6'h18)
		else $error("read slot before both address bytes");
	a_crc_first_out: assert property (rd && rcnt_q < 4'h8 |-> slot_rbit == crc_q[rcnt_q[2:0]])
		else $error("header crc bit wrong");
	a_crc_after_hdr: assert property (s_last_hdr_bit |=> s_no_write[*8])
		else $error("write slot during header crc");
	a_cmd_code_ok: assert property (wr && wcnt_q == 6'h07 |=> cmd_q == CMD_READ_PAGE || cmd_q == CMD_PROGRAM)
		else $error("unexpected command byte");
	a_pulse_after_crc: assert property (s_pulse_slot |-> is_prog && rcnt_q == 4'h8)
		else $error("pulse before crc read back");
	a_verify_reads: assert property (s_pulse_slot |=> s_no_write[*8])
		else $error("write slot during verify reads");
	a_rbit_stands: assert property (!slot_valid |=> $stable(slot_rbit))
		else $error("read line moved without a slot");
endmodule : link_sva

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import eprom_pkg::*;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        ce = 1'b1;
	logic        cmd_valid = 1'b0;
	logic        cmd_program = 1'b0;
	logic [15:0] cmd_addr = 16'h0000;
	logic [7:0]  cmd_data = 8'h00;
	logic        cmd_last = 1'b0;
	logic        rd_ready = 1'b0;
	logic [3:0]  wp_page = 4'h0;
	logic        cmd_ready, rd_valid, rd_is_crc, rd_crc_bad, done, error, prog_refused;
	logic [7:0]  rd_data;
	logic [7:0]  mem [0:127];
	int          miscompares = 0;
	int          total_checks = 0;
	int          dones = 0;
	int          errs = 0;
	int          refs = 0;
	link_if lk ();
	link_if lk2 ();
	always #25 clk = ~clk;
	eprom_host #(.PULSE_CYCLES(4)) i_eprom_host (.clk(clk), .reset(reset), .ce(ce),
		.link(lk.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_program(cmd_program), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.cmd_last(cmd_last), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
		.rd_is_crc(rd_is_crc), .rd_crc_bad(rd_crc_bad), .done(done), .error(error));
	eprom_dev i_eprom_dev (.clk(clk), .reset(reset), .ce(ce), .link(lk.device),
		.wp_page(wp_page), .prog_refused(prog_refused));
	// Second device, driven slot by slot from the bench
	eprom_dev i_eprom_dev_2 (.clk(clk), .reset(reset), .ce(ce), .link(lk2.device),
		.wp_page(wp_page), .prog_refused());
	link_sva i_link_sva (.clk(clk), .reset(reset), .slot_valid(lk.slot_valid),
		.slot_kind(lk.slot_kind), .slot_wbit(lk.slot_wbit), .slot_rbit(lk.slot_rbit));
	always @(posedge clk) begin
		if (done === 1'b1) dones++;
		if (done === 1'b1 && error === 1'b1) errs++;
		if (prog_refused === 1'b1) refs++;
	end
	task check(input logic [9:0] seen, input logic [9:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] d);
		for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
		return c;
	endfunction : crc_byte
	task final_report;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : final_report
	task host_cmd(input logic p, input logic [15:0] a, input logic [7:0] d, input logic l);
		int n;
		n = 0;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_program <= p;
		cmd_addr <= a;
		cmd_data <= d;
		cmd_last <= l;
		do begin @(posedge clk); n++; end while (cmd_ready !== 1'b1 && n < 400);
		cmd_valid <= 1'b0;
		check(10'(cmd_ready), 10'h001);
	endtask : host_cmd
	task wait_for(input int target);
		int n;
		n = 0;
		while (dones < target && n < 20000) begin @(posedge clk); n++; end
		check(10'(dones), 10'(target));
	endtask : wait_for
	task get(output logic [9:0] w);
		int n;
		n = 0;
		@(posedge clk);
		rd_ready <= 1'b1;
		do begin @(posedge clk); n++; end while (rd_valid !== 1'b1 && n < 500);
		w = {rd_is_crc, rd_crc_bad, rd_data};
		rd_ready <= 1'b0;
	endtask : get
	task slot(input logic [1:0] k, input logic b, output logic r);
		@(posedge clk);
		lk2.slot_valid <= 1'b1;
		lk2.slot_kind <= k;
		lk2.slot_wbit <= b;
		@(posedge clk);
		r = lk2.slot_rbit;
		lk2.slot_valid <= 1'b0;
	endtask : slot
	task wbyte(input logic [7:0] d);
		logic r;
		for (int i = 0; i < 8; i++) slot(SLOT_WRITE, d[i], r);
	endtask : wbyte
	task rbyte(output logic [7:0] d);
		logic r;
		for (int i = 0; i < 8; i++) begin slot(SLOT_READ, 1'b0, r); d[i] = r; end
	endtask : rbyte
	// Two beats crossing a page edge, then clear-only overwrite
	task t_program;
		host_cmd(1'b1, 16'h001f, 8'ha5, 1'b0);
		host_cmd(1'b1, 16'h0000, 8'h3c, 1'b1);
		wait_for(1);
		check(10'(errs), 10'h000);
		mem[31] = mem[31] & 8'ha5;
		mem[32] = mem[32] & 8'h3c;
		host_cmd(1'b1, 16'h001f, 8'h0f, 1'b1);
		wait_for(2);
		check(10'(errs), 10'h000);
		mem[31] = mem[31] & 8'h0f;
	endtask : t_program
	task t_protect;
		wp_page <= 4'h4;
		host_cmd(1'b1, 16'h0045, 8'h00, 1'b1);
		wait_for(3);
		check(10'(errs), 10'h001);
		check(10'(refs), 10'h004);
		wp_page <= 4'h0;
	endtask : t_protect
	// Long stall first so the buffer fills and the host holds off
	task t_read(input logic [15:0] a);
		logic [9:0] w;
		logic [7:0] c;
		host_cmd(1'b0, a, 8'h00, 1'b1);
		repeat (200) @(posedge clk);
		check(10'(lk.slot_valid), 10'h000);
		for (int p = int'(a[6:5]); p < 4; p++) begin
			c = 8'h00;
			for (int b = (p == int'(a[6:5])) ? int'(a[4:0]) : 0; b < 32; b++) begin
				get(w);
				check(w, {2'b00, mem[p * 32 + b]});
				c = crc_byte(c, mem[p * 32 + b]);
			end
			get(w);
			check(w, {2'b10, c});
		end
		wait_for(4);
		check(10'(errs), 10'h001);
	endtask : t_read
	task t_direct;
		logic [7:0] v;
		logic       r;
		slot(SLOT_RESET, 1'b0, r);
		wbyte(CMD_PROGRAM);
		wbyte(8'h85);
		wbyte(8'h01);
		wbyte(8'h7e);
		rbyte(v);
		check(10'(v), 10'(crc_byte(crc_byte(crc_byte(crc_byte(8'h00, 8'h0f), 8'h05), 8'h00),
			8'h7e)));
		slot(SLOT_PULSE, 1'b0, r);
		rbyte(v);
		check(10'(v), 10'h07e);
		// Slots while frozen must move nothing, so the CRC below is unchanged
		ce <= 1'b0;
		wbyte(8'h00);
		ce <= 1'b1;
		wbyte(8'he7);
		rbyte(v);
		check(10'(v), 10'(crc_byte(8'h06, 8'he7)));
		for (int i = 0; i < 3; i++) slot(SLOT_WRITE, 1'b1, r);
		slot(SLOT_RESET, 1'b0, r);
		wbyte(CMD_READ_PAGE);
		wbyte(8'h7f);
		wbyte(8'h00);
		rbyte(v);
		check(10'(v), 10'(crc_byte(crc_byte(crc_byte(8'h00, 8'hc3), 8'h7f), 8'h00)));
		rbyte(v);
		check(10'(v), 10'h0ff);
		rbyte(v);
		check(10'(v), 10'(crc_byte(8'h00, 8'hff)));
		rbyte(v);
		check(10'(v), 10'h0ff);
	endtask : t_direct
	initial begin
		lk2.slot_valid = 1'b0;
		lk2.slot_kind = SLOT_RESET;
		lk2.slot_wbit = 1'b0;
		for (int i = 0; i < 128; i++) mem[i] = ERASED_BYTE;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		t_program();
		t_protect();
		t_read(16'h001e);
		t_direct();
		final_report();
	end
	// Run needs well under 10000 cycles
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		final_report();
	end
endmodule : tb_top
